// *** verilog/scrb_pkg.sv ***
// register map, reset values and carrier types of the sensor control register bank
package scrb_pkg;
  // register byte addresses; wider registers are big-endian from the base
  localparam logic [15:0] ADR_MODEL = 16'h8000;
  localparam logic [15:0] ADR_REV = 16'h8002;
  localparam logic [15:0] ADR_HW_EN = 16'h8102;
  localparam logic [15:0] ADR_SYNC = 16'h8500;
  localparam logic [15:0] ADR_FEAT_A = 16'h8502;
  localparam logic [15:0] ADR_FEAT_B = 16'h8503;
  localparam logic [15:0] ADR_STATUS = 16'h8504;
  localparam logic [15:0] ADR_SW_W = 16'h8508;
  localparam logic [15:0] ADR_SW_H = 16'h850a;
  localparam logic [15:0] ADR_SW_X = 16'h850c;
  localparam logic [15:0] ADR_SW_Y = 16'h850e;
  localparam logic [15:0] ADR_CLK_PS = 16'h8518;
  localparam logic [15:0] ADR_FPS = 16'h851c;
  localparam logic [15:0] ADR_STRENGTH = 16'h8522;
  localparam logic [15:0] ADR_UPPER = 16'h852c;
  localparam logic [15:0] ADR_LOW_MIN = 16'h8530;
  localparam logic [15:0] ADR_LOW_MAX = 16'h8532;
  localparam logic [15:0] ADR_ROM = 16'h853c;
  localparam logic [15:0] ADR_PATCH = 16'h857c;
  localparam logic [2:0] LEN_B = 3'h1;
  localparam logic [2:0] LEN_H = 3'h2;
  localparam logic [2:0] LEN_W = 3'h4;
  // reset values
  localparam logic [7:0] RST_HW_EN = 8'h7f;
  localparam logic [31:0] RST_ROM = 32'h0200_0089;
  // commit handshake and field positions
  localparam logic [7:0] SYNC_IDLE = 8'h00;
  localparam logic [7:0] SYNC_COMMIT = 8'h03;
  localparam int STATUS_BOOT_OK = 5;
  localparam int FEAT_B_FRAME = 0;
  // frame timing: clocks per line and the blanking window in lines
  localparam logic [26:0] LINE_CLOCKS = 27'h000_052a;
  localparam logic [32:0] BLANK_MIN = 33'h0_0000_0028;
  localparam logic [32:0] BLANK_MAX = 33'h0_0000_0dff;
  localparam logic [4:0] DIV_LAST = 5'h1f;
  typedef struct packed {
    logic rsv; logic remap; logic sharpen; logic defect;
    logic reorder; logic fpn; logic dark_gain; logic dark_offset;
  } scrb_hw_en_s;
  typedef struct packed {
    logic remap; logic feat6; logic aec; logic abc; logic [3:0] low;
  } scrb_feat_a_s;
  typedef struct packed {
    scrb_feat_a_s feat_a; logic [7:0] feat_b;
    logic [15:0] sw_w; logic [15:0] sw_h; logic [15:0] sw_x; logic [15:0] sw_y;
    logic [31:0] clk_ps; logic [15:0] fps; logic [7:0] strength;
    logic [31:0] upper; logic [15:0] low_min; logic [15:0] low_max;
  } scrb_params_s;
  typedef struct packed {
    logic ptr_hi_we; logic ptr_lo_we; logic data_we; logic ack_rise; logic [7:0] wdata;
  } scrb_ser_req_s;
  typedef struct packed {
    logic we; logic done; logic ok; logic [15:0] addr; logic [7:0] data;
  } scrb_boot_req_s;
  localparam scrb_params_s PRM_RST = '{feat_a: 8'hf0, feat_b: 8'h00, sw_w: 16'h0400,
    sw_h: 16'h0200, sw_x: 16'h0000, sw_y: 16'h0000, clk_ps: 32'h019b_fcc0, fps: 16'h001e,
    strength: 8'h03, upper: 32'h0000_05dc, low_min: 16'h0200, low_max: 16'h1c00};
  typedef struct packed {
    logic booting; logic [15:0] ptr; scrb_hw_en_s hw_en; logic [7:0] sync;
    logic [7:0] stat; logic [31:0] patch; scrb_params_s prm; scrb_params_s act;
    logic [7:0] rdata; logic commit; logic div_busy; logic [4:0] div_cnt;
    logic [26:0] rem; logic [31:0] quo; logic [26:0] dsr;
    logic [15:0] frame_len; logic frame_upd;
  } scrb_state_s;
  localparam scrb_state_s ST_RST = '{booting: 1'b1, hw_en: RST_HW_EN, prm: PRM_RST,
    act: PRM_RST, default: '0};
endpackage

// *** verilog/scrb_register_bank.sv ***
// control and status register bank of the image sensor
`timescale 1ns/1ps
// Operation
// - pointer steps by one at the acknowledge-start strobe of each data byte.
// - host reaches registers only through the serial slave byte strobes.
// - boot loader writes override defaults before host access opens.
// - two-byte model code reads at two addresses, high byte first.
// - one-byte read-only silicon revision at its own address.
// - four read-only ROM version bytes: major, minor, minor-minor, build.
// - status bit 5 set after successful boot load; else patch invalid.
// - four read-only patch version bytes; all zero means no patch.
// - hardware enable register resets with every function enabled.
// - enable bits 6 remap, 5 sharpen, 4 defect, 2 fixed-pattern noise.
// - bit 0 dark offset correction, bit 1 dark gain correction.
// - host waits for sync zero, then writes 0x03 to commit parameters.
// - feature bits 7 remap, 5 exposure, 4 barrier; bits 6:4 default set.
// - 32-bit upper histogram pixel limit drives compression.
// - 16-bit lower histogram min and max pixel counts drive exposure.
// - one-byte remap strength, lower means smaller histogram change.
// - frame rate applies only while second feature bit 0 is set.
// - closest frame length in lines, clamped to rows plus 40 to 3583.
module scrb_register_bank #(
  parameter logic [15:0] MODEL_ID = 16'h5a3c, // arbitrary value
  parameter logic [7:0] REVISION = 8'h07, // arbitrary value
  parameter logic [31:0] ROM_VERSION = scrb_pkg::RST_ROM
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // byte strobes from the serial slave engine
  input wire scrb_pkg::scrb_ser_req_s ser,
  output logic [7:0] rdata,
  // boot loader write path
  input wire scrb_pkg::scrb_boot_req_s boot,
  output logic boot_busy,
  // towards the image pipeline and firmware
  output scrb_pkg::scrb_hw_en_s hw_enables,
  output scrb_pkg::scrb_params_s active,
  output logic params_commit,
  output logic [15:0] frame_length_lines,
  output logic frame_length_update
);

  scrb_pkg::scrb_state_s s;
  scrb_pkg::scrb_state_s next_s;
  logic wen;
  logic [15:0] wa;
  logic [7:0] wd;
  logic [27:0] t;
  logic [32:0] q;
  logic [32:0] lo;
  logic [32:0] hi;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] base,
                               input logic [2:0] n);
    return (a >= base) && ({1'b0, a} < ({1'b0, base} + 17'(n)));
  endfunction

  function automatic logic [31:0] wb32(input logic [31:0] v, input logic [1:0] i,
                                       input logic [7:0] d);
    logic [31:0] r;
    r = v;
    r[8 * (3 - i) +: 8] = d;
    return r;
  endfunction

  function automatic logic [15:0] wb16(input logic [15:0] v, input logic i,
                                       input logic [7:0] d);
    logic [15:0] r;
    r = v;
    r[8 * (1 - i) +: 8] = d;
    return r;
  endfunction

  function automatic logic [7:0] rb32(input logic [31:0] v, input logic [1:0] i);
    return v[8 * (3 - i) +: 8];
  endfunction

  function automatic logic [7:0] rb16(input logic [15:0] v, input logic i);
    return v[8 * (1 - i) +: 8];
  endfunction

  // byte seen by the host at address a; unmapped bytes read zero
  function automatic logic [7:0] rd(input logic [15:0] a, input scrb_pkg::scrb_state_s st);
    logic [7:0] r;
    r = 8'h00;
    if (hit(a, scrb_pkg::ADR_MODEL, scrb_pkg::LEN_H)) r = rb16(MODEL_ID, a[0]);
    if (hit(a, scrb_pkg::ADR_REV, scrb_pkg::LEN_B)) r = REVISION;
    if (hit(a, scrb_pkg::ADR_HW_EN, scrb_pkg::LEN_B)) r = st.hw_en;
    if (hit(a, scrb_pkg::ADR_SYNC, scrb_pkg::LEN_B)) r = st.sync;
    if (hit(a, scrb_pkg::ADR_FEAT_A, scrb_pkg::LEN_B)) r = st.prm.feat_a;
    if (hit(a, scrb_pkg::ADR_FEAT_B, scrb_pkg::LEN_B)) r = st.prm.feat_b;
    if (hit(a, scrb_pkg::ADR_STATUS, scrb_pkg::LEN_B)) r = st.stat;
    if (hit(a, scrb_pkg::ADR_SW_W, scrb_pkg::LEN_H)) r = rb16(st.prm.sw_w, a[0]);
    if (hit(a, scrb_pkg::ADR_SW_H, scrb_pkg::LEN_H)) r = rb16(st.prm.sw_h, a[0]);
    if (hit(a, scrb_pkg::ADR_SW_X, scrb_pkg::LEN_H)) r = rb16(st.prm.sw_x, a[0]);
    if (hit(a, scrb_pkg::ADR_SW_Y, scrb_pkg::LEN_H)) r = rb16(st.prm.sw_y, a[0]);
    if (hit(a, scrb_pkg::ADR_CLK_PS, scrb_pkg::LEN_W)) r = rb32(st.prm.clk_ps, a[1:0]);
    if (hit(a, scrb_pkg::ADR_FPS, scrb_pkg::LEN_H)) r = rb16(st.prm.fps, a[0]);
    if (hit(a, scrb_pkg::ADR_STRENGTH, scrb_pkg::LEN_B)) r = st.prm.strength;
    if (hit(a, scrb_pkg::ADR_UPPER, scrb_pkg::LEN_W)) r = rb32(st.prm.upper, a[1:0]);
    if (hit(a, scrb_pkg::ADR_LOW_MIN, scrb_pkg::LEN_H)) r = rb16(st.prm.low_min, a[0]);
    if (hit(a, scrb_pkg::ADR_LOW_MAX, scrb_pkg::LEN_H)) r = rb16(st.prm.low_max, a[0]);
    if (hit(a, scrb_pkg::ADR_ROM, scrb_pkg::LEN_W)) r = rb32(ROM_VERSION, a[1:0]);
    if (hit(a, scrb_pkg::ADR_PATCH, scrb_pkg::LEN_W)) r = rb32(st.patch, a[1:0]);
    return r;
  endfunction

  always_comb begin
    next_s = s;
    next_s.commit = 1'b0;
    next_s.frame_upd = 1'b0;
    t = '0;
    q = '0;
    lo = '0;
    hi = '0;
    // one cycle of read latency keeps the decode tree off the serial engine's path
    next_s.rdata = rd(s.ptr, s);
    // the host port stays shut while the boot loader owns the bank
    wen = s.booting ? boot.we : ser.data_we;
    wa = s.booting ? boot.addr : s.ptr;
    wd = s.booting ? boot.data : ser.wdata;
    if (!s.booting) begin
      if (ser.ptr_hi_we) begin
        next_s.ptr[15:8] = ser.wdata;
      end
      if (ser.ptr_lo_we) begin
        next_s.ptr[7:0] = ser.wdata;
      end
      if (ser.ack_rise) begin
        next_s.ptr = s.ptr + 16'h0001;
      end
    end
    if (s.booting && boot.done) begin
      next_s.booting = 1'b0;
      next_s.stat[scrb_pkg::STATUS_BOOT_OK] = boot.ok;
    end
    // apply: frame length division, then release of the handshake
    if (s.div_busy) begin
      t = {s.rem, s.quo[31]};
      next_s.quo = {s.quo[30:0], t >= {1'b0, s.dsr}};
      next_s.rem = (t >= {1'b0, s.dsr}) ? 27'(t - {1'b0, s.dsr}) : t[26:0];
      next_s.div_cnt = s.div_cnt + 5'h01;
      if (s.div_cnt == scrb_pkg::DIV_LAST) begin
        // round to the nearest line, then clamp into the blanking window
        q = {1'b0, next_s.quo} + 33'({next_s.rem, 1'b0} >= {1'b0, s.dsr});
        lo = 33'(s.act.sw_h) + scrb_pkg::BLANK_MIN;
        hi = 33'(s.act.sw_h) + scrb_pkg::BLANK_MAX;
        if (q < lo) begin
          q = lo;
        end else if (q > hi) begin
          q = hi;
        end
        next_s.frame_len = q[15:0];
        next_s.frame_upd = 1'b1;
        next_s.div_busy = 1'b0;
      end
    end else if (s.sync != scrb_pkg::SYNC_IDLE && !s.commit) begin
      next_s.sync = scrb_pkg::SYNC_IDLE;
    end
    if (wen) begin
      if (hit(wa, scrb_pkg::ADR_HW_EN, scrb_pkg::LEN_B)) begin
        next_s.hw_en = scrb_pkg::scrb_hw_en_s'(wd);
      end
      if (hit(wa, scrb_pkg::ADR_FEAT_A, scrb_pkg::LEN_B)) begin
        next_s.prm.feat_a = scrb_pkg::scrb_feat_a_s'(wd);
      end
      if (hit(wa, scrb_pkg::ADR_FEAT_B, scrb_pkg::LEN_B)) begin
        next_s.prm.feat_b = wd;
      end
      if (hit(wa, scrb_pkg::ADR_SW_W, scrb_pkg::LEN_H)) begin
        next_s.prm.sw_w = wb16(s.prm.sw_w, wa[0], wd);
      end
      if (hit(wa, scrb_pkg::ADR_SW_H, scrb_pkg::LEN_H)) begin
        next_s.prm.sw_h = wb16(s.prm.sw_h, wa[0], wd);
      end
      if (hit(wa, scrb_pkg::ADR_SW_X, scrb_pkg::LEN_H)) begin
        next_s.prm.sw_x = wb16(s.prm.sw_x, wa[0], wd);
      end
      if (hit(wa, scrb_pkg::ADR_SW_Y, scrb_pkg::LEN_H)) begin
        next_s.prm.sw_y = wb16(s.prm.sw_y, wa[0], wd);
      end
      if (hit(wa, scrb_pkg::ADR_CLK_PS, scrb_pkg::LEN_W)) begin
        next_s.prm.clk_ps = wb32(s.prm.clk_ps, wa[1:0], wd);
      end
      if (hit(wa, scrb_pkg::ADR_FPS, scrb_pkg::LEN_H)) begin
        next_s.prm.fps = wb16(s.prm.fps, wa[0], wd);
      end
      if (hit(wa, scrb_pkg::ADR_STRENGTH, scrb_pkg::LEN_B)) begin
        next_s.prm.strength = wd;
      end
      if (hit(wa, scrb_pkg::ADR_UPPER, scrb_pkg::LEN_W)) begin
        next_s.prm.upper = wb32(s.prm.upper, wa[1:0], wd);
      end
      if (hit(wa, scrb_pkg::ADR_LOW_MIN, scrb_pkg::LEN_H)) begin
        next_s.prm.low_min = wb16(s.prm.low_min, wa[0], wd);
      end
      if (hit(wa, scrb_pkg::ADR_LOW_MAX, scrb_pkg::LEN_H)) begin
        next_s.prm.low_max = wb16(s.prm.low_max, wa[0], wd);
      end
      // only the boot image may load the patch version
      if (s.booting && hit(wa, scrb_pkg::ADR_PATCH, scrb_pkg::LEN_W)) begin
        next_s.patch = wb32(s.patch, wa[1:0], wd);
      end
      // a commit is taken only from idle; other values are ignored
      if (hit(wa, scrb_pkg::ADR_SYNC, scrb_pkg::LEN_B) && wd == scrb_pkg::SYNC_COMMIT &&
          s.sync == scrb_pkg::SYNC_IDLE) begin
        next_s.sync = wd;
        next_s.act = s.prm;
        next_s.commit = 1'b1;
        if (s.prm.feat_b[scrb_pkg::FEAT_B_FRAME]) begin
          next_s.div_busy = 1'b1;
          next_s.div_cnt = '0;
          next_s.rem = '0;
          next_s.quo = s.prm.clk_ps;
          next_s.dsr = 27'(scrb_pkg::LINE_CLOCKS * 27'(s.prm.fps));
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= scrb_pkg::ST_RST;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign boot_busy = s.booting;
  assign hw_enables = s.hw_en;
  assign active = s.act;
  assign params_commit = s.commit;
  assign frame_length_lines = s.frame_len;
  assign frame_length_update = s.frame_upd;

  a_ptr_advance: assert property (
    @(posedge clk) disable iff (!rst_b)
    !s.booting && ser.ack_rise |=> s.ptr == $past(s.ptr) + 16'h0001)
    else $error("pointer did not step on acknowledge");

  a_host_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    !s.booting && ser.data_we && s.ptr == scrb_pkg::ADR_HW_EN
    |=> hw_enables == $past(ser.wdata))
    else $error("host write to enables lost");

  a_boot_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    s.booting && boot.we && boot.addr == scrb_pkg::ADR_HW_EN
    |=> hw_enables == $past(boot.data))
    else $error("boot write to enables lost");

  a_model_read: assert property (
    @(posedge clk) disable iff (!rst_b)
    s.ptr[15:1] == scrb_pkg::ADR_MODEL[15:1]
    |=> rdata == ($past(s.ptr[0]) ? MODEL_ID[7:0] : MODEL_ID[15:8]))
    else $error("model code byte wrong");

  a_rev_read: assert property (
    @(posedge clk) disable iff (!rst_b)
    s.ptr == scrb_pkg::ADR_REV |=> rdata == REVISION)
    else $error("revision byte wrong");

  a_rom_read: assert property (
    @(posedge clk) disable iff (!rst_b)
    s.ptr == scrb_pkg::ADR_ROM |=> rdata == ROM_VERSION[31:24] ##1 1'b1)
    else $error("rom major byte wrong");

  a_boot_flag: assert property (
    @(posedge clk) disable iff (!rst_b)
    s.booting && boot.done
    |=> s.stat[scrb_pkg::STATUS_BOOT_OK] == $past(boot.ok) && !boot_busy)
    else $error("boot status not recorded");

  a_patch_guard: assert property (
    @(posedge clk) disable iff (!rst_b)
    !s.booting |=> $stable(s.patch))
    else $error("patch version changed after boot");

  a_reset_enables: assert property (
    @(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> hw_enables == scrb_pkg::RST_HW_EN)
    else $error("enables not all set after reset");

  a_commit_copy: assert property (
    @(posedge clk) disable iff (!rst_b)
    params_commit |-> active == $past(s.prm) && s.sync == scrb_pkg::SYNC_COMMIT)
    else $error("commit did not take staged parameters");

  a_sync_release: assert property (
    @(posedge clk) disable iff (!rst_b)
    params_commit |-> s.sync != scrb_pkg::SYNC_IDLE ##[1:40] s.sync == scrb_pkg::SYNC_IDLE)
    else $error("sync register not released");

  a_frame_gate: assert property (
    @(posedge clk) disable iff (!rst_b)
    frame_length_update |-> active.feat_b[scrb_pkg::FEAT_B_FRAME])
    else $error("frame length set while frame control off");

  a_frame_clamp: assert property (
    @(posedge clk) disable iff (!rst_b)
    frame_length_update |-> 33'(frame_length_lines) >= 33'(active.sw_h) + scrb_pkg::BLANK_MIN
    && 33'(frame_length_lines) <= 33'(active.sw_h) + scrb_pkg::BLANK_MAX)
    else $error("frame length outside window");

  // write paths: parameter strobes must land in the staged copy, not only in active
  a_boot_lockout: assert property (
    @(posedge clk) disable iff (!rst_b)
    s.booting |=> s.ptr == $past(s.ptr))
    else $error("host strobe moved pointer during boot");

  a_dark_bits: assert property (
    @(posedge clk) disable iff (!rst_b)
    !s.booting && ser.data_we && s.ptr == scrb_pkg::ADR_HW_EN
    |=> {hw_enables.dark_gain, hw_enables.dark_offset} == $past(ser.wdata[1:0]))
    else $error("dark correction bits lost");

  a_feat_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    !s.booting && ser.data_we && s.ptr == scrb_pkg::ADR_FEAT_A
    |=> s.prm.feat_a == $past(ser.wdata))
    else $error("feature enable write lost");

  a_feat_reset: assert property (
    @(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> s.prm.feat_a.feat6 && s.prm.feat_a.aec && s.prm.feat_a.abc)
    else $error("feature bits not set after reset");

  a_upper_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    !s.booting && ser.data_we && s.ptr == scrb_pkg::ADR_UPPER
    |=> s.prm.upper[31:24] == $past(ser.wdata))
    else $error("upper limit write lost");

  a_lower_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    !s.booting && ser.data_we && s.ptr == scrb_pkg::ADR_LOW_MIN
    |=> s.prm.low_min[15:8] == $past(ser.wdata))
    else $error("lower minimum write lost");

  a_strength_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    !s.booting && ser.data_we && s.ptr == scrb_pkg::ADR_STRENGTH
    |=> s.prm.strength == $past(ser.wdata))
    else $error("strength write lost");

  a_commit_refuse: assert property (
    @(posedge clk) disable iff (!rst_b)
    s.sync != scrb_pkg::SYNC_IDLE |=> !params_commit)
    else $error("commit taken while busy");

  // the divide runs a fixed 32 steps, so the update lands a fixed distance after commit
  a_divide_time: assert property (
    @(posedge clk) disable iff (!rst_b)
    params_commit && active.feat_b[scrb_pkg::FEAT_B_FRAME] |-> ##32 frame_length_update)
    else $error("frame length update mistimed");

  a_sync_hold: assert property (
    @(posedge clk) disable iff (!rst_b)
    s.div_busy |-> s.sync == scrb_pkg::SYNC_COMMIT)
    else $error("sync released while applying");

endmodule // scrb_register_bank

// *** verif/scrb_host_model.sv ***
// host and boot loader model driving the register bank strobes
`timescale 1ns/1ps
module scrb_host_model (
  // clock
  input wire logic clk,
  // register bank side
  output scrb_pkg::scrb_ser_req_s ser,
  output scrb_pkg::scrb_boot_req_s boot,
  input wire logic [7:0] rdata
);
  initial begin
    ser = '0;
    boot = '0;
  end
  task automatic set_ptr(input logic [15:0] a);
    @(negedge clk);
    ser.ptr_hi_we = 1'b1;
    ser.wdata = a[15:8];
    @(negedge clk);
    ser.ptr_hi_we = 1'b0;
    ser.ptr_lo_we = 1'b1;
    ser.wdata = a[7:0];
    @(negedge clk);
    ser.ptr_lo_we = 1'b0;
  endtask
  // n bytes, big-endian from the low n bytes of v
  task automatic wr(input logic [15:0] a, input logic [31:0] v, input int n);
    set_ptr(a);
    for (int i = 0; i < n; i++) begin
      ser.data_we = 1'b1;
      ser.ack_rise = 1'b1;
      ser.wdata = v[8*(n-1-i)+:8];
      @(negedge clk);
    end
    ser.data_we = 1'b0;
    ser.ack_rise = 1'b0;
    // released data shows its inverse so a stale byte never looks fresh
    ser.wdata = ~ser.wdata;
  endtask
  task automatic rd(input logic [15:0] a, input int n, output logic [31:0] v);
    set_ptr(a);
    ser.wdata = ~ser.wdata;
    v = '0;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      v = {v[23:0], rdata};
      if (i < n - 1) begin
        ser.ack_rise = 1'b1;
        @(negedge clk);
        ser.ack_rise = 1'b0;
      end
    end
  endtask
  task automatic boot_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    boot.we = 1'b1;
    boot.addr = a;
    boot.data = d;
    @(negedge clk);
    boot.we = 1'b0;
    boot.addr = ~a;
    boot.data = ~d;
  endtask
  task automatic boot_done(input logic ok);
    @(negedge clk);
    boot.done = 1'b1;
    boot.ok = ok;
    @(negedge clk);
    boot.done = 1'b0;
    boot.ok = ~ok;
  endtask
  // a new commit is only asked for once the previous one has drained
  task automatic commit(output logic ok);
    logic [31:0] s;
    ok = 1'b0;
    for (int i = 0; i < 40 && !ok; i++) begin
      rd(scrb_pkg::ADR_SYNC, 1, s);
      ok = (s[7:0] === scrb_pkg::SYNC_IDLE);
    end
    if (ok) wr(scrb_pkg::ADR_SYNC, {24'h0, scrb_pkg::SYNC_COMMIT}, 1);
  endtask
endmodule // scrb_host_model

// *** verif/tb.sv ***
// self-checking testbench of the sensor control register bank
`timescale 1ns/1ps
module tb;
  localparam logic [15:0] ID_MODEL = 16'h6b2d; // arbitrary value
  localparam logic [7:0] ID_REV = 8'h09; // arbitrary value
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  scrb_pkg::scrb_ser_req_s ser;
  scrb_pkg::scrb_boot_req_s boot;
  logic [7:0] rdata;
  logic boot_busy;
  scrb_pkg::scrb_hw_en_s hw_enables;
  scrb_pkg::scrb_params_s active;
  logic params_commit;
  logic [15:0] frame_length_lines;
  logic frame_length_update;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  int commits = 0;
  int updates = 0;
  int c0;
  int hw_bits[6] = '{6, 5, 4, 2, 1, 0};
  logic [15:0] fps_tab[2] = '{16'h001e, 16'h0064};
  logic [15:0] last_len = '0;
  logic [31:0] v;
  logic ok;
  always #5 clk = ~clk;
  scrb_register_bank #(.MODEL_ID(ID_MODEL), .REVISION(ID_REV)) scrb_register_bank_i (
    .clk(clk), .rst_b(rst_b), .ser(ser), .rdata(rdata), .boot(boot), .boot_busy(boot_busy),
    .hw_enables(hw_enables), .active(active), .params_commit(params_commit),
    .frame_length_lines(frame_length_lines), .frame_length_update(frame_length_update));
  scrb_host_model scrb_host_model_i (.clk(clk), .ser(ser), .boot(boot), .rdata(rdata));
  always @(posedge clk) begin
    if (params_commit === 1'b1) commits <= commits + 1;
    if (frame_length_update === 1'b1) begin
      updates <= updates + 1;
      last_len <= frame_length_lines;
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  function automatic logic pick(input scrb_pkg::scrb_hw_en_s h, input int b);
    case (b)
      6: return h.remap;
      5: return h.sharpen;
      4: return h.defect;
      2: return h.fpn;
      1: return h.dark_gain;
      default: return h.dark_offset;
    endcase
  endfunction
  // nearest whole line count, clamped to the achievable blanking window
  function automatic logic [15:0] frame_exp(input logic [31:0] cps, input logic [15:0] fps,
      input logic [15:0] rows);
    longint d;
    longint q;
    d = 1322 * longint'(fps);
    q = (longint'(cps) + d / 2) / d;
    if (q < rows + 40) q = rows + 40;
    if (q > rows + 3583) q = rows + 3583;
    return q[15:0];
  endfunction
  task automatic give_verdict();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    chk("boot_busy", 32'h1, {31'h0, boot_busy});
    chk("hw_enables", 32'h7f, {24'h0, hw_enables});
    rst_b = 1'b1;
    scrb_host_model_i.wr(scrb_pkg::ADR_STRENGTH, 32'h55, 1);
    scrb_host_model_i.boot_wr(scrb_pkg::ADR_STRENGTH, 8'h21);
    for (int i = 0; i < 4; i++) begin
      scrb_host_model_i.boot_wr(scrb_pkg::ADR_PATCH + 16'(i), 8'(i + 1));
    end
    scrb_host_model_i.boot_wr(scrb_pkg::ADR_HW_EN, 8'h7b);
    scrb_host_model_i.boot_done(1'b1);
    chk("boot_busy", 32'h0, {31'h0, boot_busy});
    chk("hw_enables", 32'h7b, {24'h0, hw_enables});
    scrb_host_model_i.rd(scrb_pkg::ADR_STATUS, 1, v);
    chk("status", 32'h20, v);
    scrb_host_model_i.rd(scrb_pkg::ADR_MODEL, 3, v);
    chk("model", {8'h0, ID_MODEL, ID_REV}, v);
    scrb_host_model_i.rd(scrb_pkg::ADR_ROM, 4, v);
    chk("rom", scrb_pkg::RST_ROM, v);
    scrb_host_model_i.rd(scrb_pkg::ADR_PATCH, 4, v);
    chk("patch", 32'h0102_0304, v);
    scrb_host_model_i.rd(scrb_pkg::ADR_STRENGTH, 1, v);
    chk("strength", 32'h21, v);
    scrb_host_model_i.wr(scrb_pkg::ADR_MODEL, 32'hffff, 2);
    scrb_host_model_i.rd(scrb_pkg::ADR_MODEL, 2, v);
    chk("model", {16'h0, ID_MODEL}, v);
    foreach (hw_bits[k]) begin
      scrb_host_model_i.wr(scrb_pkg::ADR_HW_EN, 32'h08 | (32'h1 << hw_bits[k]), 1);
      chk("hw_enables", 32'h08 | (32'h1 << hw_bits[k]), {24'h0, hw_enables});
      chk("enable field", 32'h1, {31'h0, pick(hw_enables, hw_bits[k])});
    end
    scrb_host_model_i.rd(scrb_pkg::ADR_HW_EN, 1, v);
    scrb_host_model_i.wr(scrb_pkg::ADR_HW_EN, v | 32'h20, 1);
    chk("hw_enables", 32'h29, {24'h0, hw_enables});
    scrb_host_model_i.wr(scrb_pkg::ADR_FEAT_A, 32'h70, 1);
    scrb_host_model_i.wr(scrb_pkg::ADR_UPPER, 32'h0001_2345, 4);
    scrb_host_model_i.wr(scrb_pkg::ADR_LOW_MIN, 32'h0100_2000, 4);
    scrb_host_model_i.wr(scrb_pkg::ADR_STRENGTH, 32'h07, 1);
    chk("active upper", 32'h0000_05dc, active.upper);
    c0 = commits;
    scrb_host_model_i.commit(ok);
    chk("commit ok", 32'h1, {31'h0, ok});
    repeat (2) @(negedge clk);
    chk("commits", 32'(c0 + 1), 32'(commits));
    chk("active feat_a", 32'h70, {24'h0, active.feat_a});
    chk("active upper", 32'h0001_2345, active.upper);
    chk("active lower", 32'h0100_2000, {active.low_min, active.low_max});
    chk("active strength", 32'h07, {24'h0, active.strength});
    c0 = commits;
    scrb_host_model_i.wr(scrb_pkg::ADR_SYNC, 32'h05, 1);
    scrb_host_model_i.rd(scrb_pkg::ADR_SYNC, 1, v);
    chk("sync", 32'h0, v);
    chk("commits", 32'(c0), 32'(commits));
    scrb_host_model_i.wr(scrb_pkg::ADR_FEAT_B, 32'h01, 1);
    // 640 x 256 window; vertical size and start stay multiples of eight
    scrb_host_model_i.wr(scrb_pkg::ADR_SW_W, 32'h0280_0100, 4);
    scrb_host_model_i.wr(scrb_pkg::ADR_SW_X, 32'h0040_0010, 4);
    foreach (fps_tab[k]) begin
      c0 = updates;
      scrb_host_model_i.wr(scrb_pkg::ADR_FPS, {16'h0, fps_tab[k]}, 2);
      scrb_host_model_i.commit(ok);
      chk("commit ok", 32'h1, {31'h0, ok});
      chk("active fps", {16'h0, fps_tab[k]}, {16'h0, active.fps});
      scrb_host_model_i.rd(scrb_pkg::ADR_SYNC, 1, v);
      chk("sync busy", 32'h03, v);
      repeat (40) @(negedge clk);
      chk("updates", 32'(c0 + 1), 32'(updates));
      chk("frame length", {16'h0, frame_exp(32'h019b_fcc0, fps_tab[k], 16'h0100)},
        {16'h0, last_len});
    end
    chk("active window", 32'h0280_0100, {active.sw_w, active.sw_h});
    chk("active start", 32'h0040_0010, {active.sw_x, active.sw_y});
    scrb_host_model_i.wr(scrb_pkg::ADR_FEAT_B, 32'h00, 1);
    c0 = updates;
    scrb_host_model_i.commit(ok);
    chk("commit ok", 32'h1, {31'h0, ok});
    repeat (40) @(negedge clk);
    chk("updates", 32'(c0), 32'(updates));
    give_verdict();
  end
endmodule // tb
